// ---- verilog/uart_mode_pkg.sv ----
// package: register map, field layout and carriers for the serial port mode block
package uart_mode_pkg;

   localparam logic [11:0] mode_offset = 12'h000;
   localparam logic [11:0] status_offset = 12'h004;
   localparam logic [31:0] mode_write_mask = 32'h0000_bbff;
   localparam logic [31:0] mode_reset = 32'h0000_0000;
   localparam logic [31:0] read_zero = 32'h0000_0000;

   localparam int port_enable_bit = 15;
   localparam int stop_in_idle_bit = 13;
   localparam int infrared_bit = 12;
   localparam int request_mode_bit = 11;
   localparam int pin_usage_lo = 8;
   localparam int wake_bit = 7;
   localparam int loopback_bit = 6;

   localparam logic [1:0] usage_tx_rx = 2'h0;
   localparam logic [1:0] usage_rts = 2'h1;
   localparam logic [1:0] usage_cts_rts = 2'h2;
   localparam logic [1:0] usage_bclk = 2'h3;

   typedef enum {
      bus_idle,
      bus_access
   } bus_state_t;

   // decoded mode fields
   typedef struct packed {
      logic port_enable;
      logic stop_in_idle;
      logic infrared_codec_enable;
      logic request_pin_mode;
      logic [1:0] pin_usage_select;
      logic wake_enable;
      logic loopback_select;
   } mode_fields_t;

   // which pins the serial port owns
   typedef struct packed {
      logic tx;
      logic rx;
      logic cts;
      logic rts;
      logic bclk;
   } pin_owner_t;

endpackage

// ---- verilog/uart_pin_select.sv ----
// pin ownership decode from enable and pin usage field
`timescale 1ns/1ps
module uart_pin_select
   import uart_mode_pkg::*;
(
   // mode
   input wire mode_fields_t mode,
   input wire logic transmit_enable,
   input wire logic routing_override,
   // ownership
   output pin_owner_t owner
);

   always_comb begin
      owner = '0;
      if (mode.port_enable && !routing_override) begin
         owner.tx = transmit_enable;
         owner.rx = 1'b1;
         case (mode.pin_usage_select)
            usage_bclk: begin
               owner.bclk = 1'b1;
            end
            usage_cts_rts: begin
               owner.cts = 1'b1;
               owner.rts = 1'b1;
            end
            usage_rts: begin
               owner.rts = 1'b1;
            end
            default: begin
               owner.cts = 1'b0;
            end
         endcase
      end
   end

endmodule

// ---- verilog/uart_mode_control.sv ----
// serial port mode register, pin muxing and line path control
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module uart_mode_control
   import uart_mode_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device power state and core hooks
   input wire logic device_idle,
   input wire logic device_sleep,
   input wire logic transmit_enable,
   input wire logic routing_override,
   input wire logic core_tx_data,
   input wire logic core_rts_level,
   input wire logic core_bclk,
   // gpio fallback drive
   input wire logic gpio_latch_register_tx,
   input wire logic gpio_latch_register_rts,
   input wire logic gpio_latch_register_bclk,
   input wire logic gpio_direction_out_tx,
   input wire logic gpio_direction_out_rts,
   input wire logic gpio_direction_out_bclk,
   // pins
   input wire logic serial_receive_pin,
   input wire logic clear_to_send_pin_n,
   output logic serial_transmit_pin_o,
   output logic serial_transmit_pin_oe,
   output logic request_to_send_pin_n_o,
   output logic request_to_send_pin_n_oe,
   output logic baud_clock_pin_o,
   output logic baud_clock_pin_oe,
   // to core and system
   output logic core_rx_data,
   output logic core_cts_level,
   output logic gpio_port_register_rx,
   output logic gpio_port_register_cts,
   output logic port_active,
   output logic port_clock_gate,
   output logic infrared_active,
   output logic simplex_mode,
   output logic wake_request,
   output logic loopback_active
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      bus_state_t bus;
      logic [31:0] mode;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic rx_s1;
      logic rx_s2;
      logic cts_s1;
      logic cts_s2;
      logic rx_prev;
      logic tx_o;
      logic tx_oe;
      logic rts_o;
      logic rts_oe;
      logic bclk_o;
      logic bclk_oe;
      logic rx_core;
      logic cts_core;
      logic gpio_rx;
      logic gpio_cts;
      logic active;
      logic clk_gate;
      logic ir;
      logic simplex;
      logic wake;
      logic loop;
   } state_t;

   state_t state;
   state_t next_state;
   mode_fields_t fields;
   pin_owner_t owner;

   assign fields.port_enable = state.mode[port_enable_bit];
   assign fields.stop_in_idle = state.mode[stop_in_idle_bit];
   assign fields.infrared_codec_enable = state.mode[infrared_bit];
   assign fields.request_pin_mode = state.mode[request_mode_bit];
   assign fields.pin_usage_select = state.mode[pin_usage_lo +: 2];
   assign fields.wake_enable = state.mode[wake_bit];
   assign fields.loopback_select = state.mode[loopback_bit];

   uart_pin_select u_pin_select (
      .mode(fields),
      .transmit_enable(transmit_enable),
      .routing_override(routing_override),
      .owner(owner)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic run;
      logic tx_line;
      logic rx_line;
      logic rx_decoded;
      run = 1'b0;
      tx_line = 1'b0;
      rx_line = 1'b0;
      rx_decoded = 1'b0;
      next_state = state;

      // apb: one wait-free access phase, answered on the first access cycle
      next_state.ready = 1'b0;
      next_state.err = 1'b0;
      case (state.bus)
         bus_idle: begin
            if (psel && !penable) begin
               next_state.bus = bus_access;
               next_state.ready = 1'b1;
               if (!pwrite) begin
                  case (paddr)
                     mode_offset: next_state.rdata = state.mode & mode_write_mask;
                     status_offset: next_state.rdata = {26'h0, state.wake, state.loop,
                        state.simplex, state.ir, state.clk_gate, state.active};
                     default: next_state.rdata = read_zero;
                  endcase
               end
               next_state.err = (paddr != mode_offset) && (paddr != status_offset);
            end
         end
         bus_access: begin
            if (psel && penable && pwrite && paddr == mode_offset) begin
               next_state.mode = pwdata & mode_write_mask;
            end
            next_state.bus = bus_idle;
         end
         default: begin
            next_state.bus = bus_idle;
         end
      endcase

      // synchronisers: only stage two is read
      next_state.rx_s1 = serial_receive_pin;
      next_state.rx_s2 = state.rx_s1;
      next_state.cts_s1 = clear_to_send_pin_n;
      next_state.cts_s2 = state.cts_s1;
      next_state.rx_prev = state.rx_s2;

      run = fields.port_enable && !(fields.stop_in_idle && device_idle);
      next_state.active = run;
      next_state.clk_gate = !run;
      next_state.ir = run && fields.infrared_codec_enable;
      next_state.simplex = fields.request_pin_mode;
      next_state.loop = run && fields.loopback_select;

      // infrared: high data bit idles line low, low data bit gives a pulse
      tx_line = fields.infrared_codec_enable ? !core_tx_data : core_tx_data;
      rx_decoded = fields.infrared_codec_enable ? !state.rx_s2 : state.rx_s2;

      // loopback: transmit pin is held high, data returns inside
      rx_line = fields.loopback_select ? core_tx_data : rx_decoded;
      next_state.rx_core = run ? rx_line : 1'b1;

      next_state.tx_o = owner.tx ? (fields.loopback_select ? 1'b1 : tx_line)
         : gpio_latch_register_tx;
      next_state.tx_oe = owner.tx ? 1'b1 : gpio_direction_out_tx;
      // simplex: rts is a direction level; flow control: ready-to-receive
      next_state.rts_o = owner.rts ? (run ? core_rts_level : 1'b1)
         : gpio_latch_register_rts;
      next_state.rts_oe = owner.rts ? 1'b1 : gpio_direction_out_rts;
      next_state.bclk_o = owner.bclk ? (run && core_bclk) : gpio_latch_register_bclk;
      next_state.bclk_oe = owner.bclk ? 1'b1 : gpio_direction_out_bclk;
      next_state.cts_core = owner.cts ? state.cts_s2 : 1'b0;
      next_state.gpio_rx = state.rx_s2;
      next_state.gpio_cts = state.cts_s2;

      // wake on falling receive edge while asleep; held until sleep ends or wake or port enable is cleared
      if (!device_sleep || !fields.wake_enable || !fields.port_enable) begin
         next_state.wake = 1'b0;
      end
      if (device_sleep && fields.wake_enable && fields.port_enable
          && state.rx_prev && !state.rx_s2) begin
         next_state.wake = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
         state.bus <= bus_idle;
         state.mode <= mode_reset;
         state.rx_s1 <= 1'b1;
         state.rx_s2 <= 1'b1;
         state.rx_prev <= 1'b1;
         state.cts_s1 <= 1'b1;
         state.cts_s2 <= 1'b1;
         state.rx_core <= 1'b1;
         state.clk_gate <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign prdata = state.rdata;
   assign pready = state.ready;
   assign pslverr = state.err;
   assign serial_transmit_pin_o = state.tx_o;
   assign serial_transmit_pin_oe = state.tx_oe;
   assign request_to_send_pin_n_o = state.rts_o;
   assign request_to_send_pin_n_oe = state.rts_oe;
   assign baud_clock_pin_o = state.bclk_o;
   assign baud_clock_pin_oe = state.bclk_oe;
   assign core_rx_data = state.rx_core;
   assign core_cts_level = state.cts_core;
   assign gpio_port_register_rx = state.gpio_rx;
   assign gpio_port_register_cts = state.gpio_cts;
   assign port_active = state.active;
   assign port_clock_gate = state.clk_gate;
   assign infrared_active = state.ir;
   assign simplex_mode = state.simplex;
   assign wake_request = state.wake;
   assign loopback_active = state.loop;

endmodule

// ---- tb/uart_peer_model.sv ----
// serial peer: start bit on the receive line and a flow-control level
`timescale 1ns/1ps
module uart_peer_model (
   // clock and command
   input wire logic pclk,
   input wire logic send,
   // lines toward the port
   output logic rx_line,
   output logic cts_line_n
);
   int cnt = 0;
   logic send_d = 1'b0;
   always @(posedge pclk) begin
      send_d <= send;
      if (send && !send_d) begin
         cnt <= 8;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   // line idles high, low for one start bit
   assign rx_line = (cnt == 0);
   assign cts_line_n = ~send_d;
endmodule

// ---- tb/uart_mode_control_asserts.sv ----
// checker: bus answer, mode decode and wake relations of the mode block
`timescale 1ns/1ps
module uart_mode_control_asserts
   import uart_mode_pkg::*;
(
   // clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // system and pins
   input wire logic device_idle,
   input wire logic device_sleep,
   input wire logic routing_override,
   input wire logic serial_receive_pin,
   input wire logic baud_clock_pin_oe,
   // decoded state
   input wire logic port_active,
   input wire logic port_clock_gate,
   input wire logic loopback_active,
   input wire logic wake_request
);
   logic [31:0] m;
   logic act;
   logic lb;
   logic run;
   assign run = m[port_enable_bit] & ~(m[stop_in_idle_bit] & device_idle);
   // shadow of the mode register and its registered decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m <= mode_reset;
         act <= 1'b0;
         lb <= 1'b0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == mode_offset) begin
            m <= pwdata & mode_write_mask;
         end
         act <= run;
         lb <= run & m[loopback_bit];
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence start_s;
      $fell(serial_receive_pin) && device_sleep && m[wake_bit] && m[port_enable_bit];
   endsequence
   a_ready_after_setup: assert property (setup_s |=> pready)
      else $error("no answer after setup");
   a_unmapped_err: assert property (pready && !pwrite && paddr != mode_offset &&
      paddr != status_offset |-> pslverr && prdata == read_zero)
      else $error("unmapped read not refused");
   a_mode_readback: assert property (pready && !pwrite && paddr == mode_offset |-> prdata == m)
      else $error("mode read differs");
   a_active_mode: assert property (port_active == act)
      else $error("active level wrong");
   a_gate_off: assert property (port_clock_gate == !act)
      else $error("clock gate wrong");
   a_loop_mode: assert property (loopback_active == lb)
      else $error("loopback level wrong");
   a_bclk_owned: assert property (act && m[9:8] == usage_bclk && m == $past(m, 2) &&
      !$past(routing_override) |-> baud_clock_pin_oe)
      else $error("baud clock not driven");
   a_wake_start: assert property (start_s |-> ##[1:6] wake_request)
      else $error("no wake after start bit");
endmodule
bind uart_mode_control uart_mode_control_asserts chk_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .device_idle, .device_sleep,
   .routing_override, .serial_receive_pin, .baud_clock_pin_oe, .port_active,
   .port_clock_gate, .loopback_active, .wake_request);

// ---- tb/tb_uart_mode_control.sv ----
// testbench: mode register, pin ownership, loopback and wake of the serial port
`timescale 1ns/1ps
module tb_uart_mode_control import uart_mode_pkg::*;;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic device_idle = 1'b0;
   logic device_sleep = 1'b0;
   logic routing_override = 1'b0;
   logic transmit_enable = 1'b1;
   logic send = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [8:0] v = 9'h000;
   logic [31:0] seed = 32'ha973;
   logic [31:0] prdata, q, r, mdl;
   logic pready, pslverr, e, serial_receive_pin, clear_to_send_pin_n, serial_transmit_pin_o;
   logic serial_transmit_pin_oe, request_to_send_pin_n_oe, baud_clock_pin_oe;
   logic core_rx_data, wake_request, request_to_send_pin_n_o, baud_clock_pin_o, core_cts_level;
   logic gpio_port_register_rx, gpio_port_register_cts, port_active, port_clock_gate;
   logic infrared_active, simplex_mode, loopback_active;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;
   always #25 pclk = ~pclk;
   uart_mode_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .device_idle, .device_sleep, .transmit_enable,
      .routing_override, .core_tx_data(v[0]), .core_rts_level(v[1]), .core_bclk(v[2]),
      .gpio_latch_register_tx(v[3]), .gpio_latch_register_rts(v[4]),
      .gpio_latch_register_bclk(v[5]), .gpio_direction_out_tx(v[6]),
      .gpio_direction_out_rts(v[7]), .gpio_direction_out_bclk(v[8]),
      .serial_receive_pin, .clear_to_send_pin_n, .serial_transmit_pin_o,
      .serial_transmit_pin_oe, .request_to_send_pin_n_o, .request_to_send_pin_n_oe,
      .baud_clock_pin_o, .baud_clock_pin_oe, .core_rx_data, .core_cts_level,
      .gpio_port_register_rx, .gpio_port_register_cts, .port_active,
      .port_clock_gate, .infrared_active, .simplex_mode, .wake_request,
      .loopback_active);
   uart_peer_model peer (.pclk, .send, .rx_line(serial_receive_pin),
      .cts_line_n(clear_to_send_pin_n));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // status word: wake, loopback, simplex, infrared, gate, active
   function logic [31:0] st(input logic [31:0] m, input logic i);
      logic a;
      a = m[15] & ~(m[13] & i);
      return {26'h0, 1'b0, a & m[6], m[11], a & m[12], ~a, a};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task test_done;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, mode_offset, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, status_offset, 32'h0);
      chk(q, st(32'h0, 1'b0));
      for (int k = 0; k < 10; k++) begin
         r = rnd();
         r[15] = r[15] | k[0];
         device_idle <= r[16];
         apb(1'b1, mode_offset, r);
         mdl = r & 32'h0000_bbff;
         apb(1'b0, mode_offset, 32'h0);
         chk(q, mdl);
         apb(1'b0, status_offset, 32'h0);
         chk(q, st(mdl, r[16]));
         chk({loopback_active, simplex_mode, infrared_active, port_clock_gate, port_active},
            st(mdl, r[16]) & 32'h0000_001f);
      end
      apb(1'b1, 12'h008, 32'hffff_ffff);
      apb(1'b0, 12'h008, 32'h0);
      chk({e, q}, {1'b1, 32'h0});
      apb(1'b0, mode_offset, 32'h0);
      chk(q, mdl);
      device_idle <= 1'b0;
      // 0..3 owned, 4..7 routing override, 8..11 disabled
      for (int k = 0; k < 12; k++) begin
         r = rnd();
         v <= r[8:0];
         transmit_enable <= r[9];
         routing_override <= k[2];
         apb(1'b1, mode_offset, {16'h0, ~k[3], 5'h0, k[1:0], 8'h0});
         repeat (3) @(posedge pclk);
         chk(serial_transmit_pin_oe, ((k < 4) & r[9]) | v[6]);
         chk(serial_transmit_pin_o, ((k < 4) & r[9]) ? v[0] : v[3]);
         chk(request_to_send_pin_n_o, ((k < 4) & (k[1] ^ k[0])) ? v[1] : v[4]);
         chk(baud_clock_pin_o, ((k < 4) & (k[1:0] == 2'h3)) ? v[2] : v[5]);
         chk(core_cts_level, (k == 2));
         chk({gpio_port_register_rx, gpio_port_register_cts}, 2'h3);
         chk(request_to_send_pin_n_oe, ((k < 4) & (k[1] ^ k[0])) | v[7]);
         chk(baud_clock_pin_oe, ((k < 4) & (k[1:0] == 2'h3)) | v[8]);
      end
      v <= 9'h000;
      transmit_enable <= 1'b1;
      apb(1'b1, mode_offset, 32'h8040);
      repeat (5) @(posedge pclk);
      chk(serial_transmit_pin_o, 1'b1);
      chk(core_rx_data, 1'b0);
      for (int k = 0; k < 2; k++) begin
         device_sleep <= 1'b1;
         apb(1'b1, mode_offset, k[0] ? 32'h8080 : 32'h8000);
         send <= 1'b1;
         n = 0;
         while (wake_request !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
         end
         chk(wake_request, k[0]);
         device_sleep <= 1'b0;
         send <= 1'b0;
         repeat (3) @(posedge pclk);
         chk(wake_request, 1'b0);
      end
      // reset in mid-run brings every mode field back to zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, mode_offset, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, status_offset, 32'h0);
      chk(q, st(32'h0, 1'b0));
      chk({port_active, port_clock_gate, core_rx_data}, 3'h3);
      test_done();
   end
endmodule
